// file: inc/sba_regs.svh
// Register addresses, field positions, reset values and sizes of the system bus arbiter.
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SBA_A_LAYER_PRIO 32'h50060400
`define SBA_A_BRIDGE 32'h50060404
`define SBA_A_FLASH_ARB 32'h50060408
`define SBA_A_STATUS 32'h5006040C
`define SBA_A_PRIO1 32'h30020000
`define SBA_A_PRIO2 32'h30020004
`define SBA_A_PRIO3 32'h30020008
`define SBA_A_DFLT 32'h30020048
`define SBA_A_WT_EN 32'h3002004C
`define SBA_A_PERIOD 32'h30020050
`define SBA_A_BUDGET1 32'h30020054
`define SBA_A_BUDGET2 32'h30020058
`define SBA_A_BUDGET3 32'h3002005C
`define SBA_A_VERSION 32'h30020090

// ----------------------------------------
// Sizes and field positions
// ----------------------------------------
`define SBA_NLAYER 4
`define SBA_NDMA 3
`define SBA_LPRIO_W 2
`define SBA_MPRIO_W 4
`define SBA_DFLT_W 4
`define SBA_CNT_W 16
`define SBA_BRIDGE_BYP_BIT 0
`define SBA_SYNC_BYP_BIT 1
`define SBA_PER_BURST_BIT 0
`define SBA_WT_ON_BIT 0
`define SBA_ST_DGNT_LSB 4
`define SBA_ST_DID_LSB 8
`define SBA_ST_TIER_LSB 12

// ----------------------------------------
// Reset values
// ----------------------------------------
// Layer order from bit 0 upward: radio controller, cpu system, cpu code, dma.
`define SBA_LPRIO_RST {2'h3, 2'h2, 2'h1, 2'h0}
`define SBA_MPRIO_RST {4'hD, 4'hE, 4'hF}
`define SBA_DFLT_RST 4'h0
`define SBA_PERIOD_RST 16'hFFFF
`define SBA_BUDGET_RST 16'h000F
`define SBA_DFLT_MAX 4'h3

`endif

// file: inc/sba_pkg.sv
// Types shared by the system bus arbiter files.
`include "sba_regs.svh"

package sba_pkg;

  typedef enum logic [1:0] {
    SBA_DM_DUMMY = 2'h0,
    SBA_DM_RADIO_TEST_PORT = 2'h1,
    SBA_DM_GENERAL_DMA = 2'h2,
    SBA_DM_ITEM_A = 2'h3
  } sba_dma_id_t;

  typedef struct packed {
    logic [`SBA_NLAYER*`SBA_LPRIO_W-1:0] layer_prio;
    logic sync_byp;
    logic bridge_byp;
    logic per_burst;
    logic [`SBA_NDMA-1:0][`SBA_MPRIO_W-1:0] mprio;
    logic [`SBA_DFLT_W-1:0] dflt;
    logic wt_on;
    logic [`SBA_CNT_W-1:0] period;
    logic [`SBA_NDMA-1:0][`SBA_CNT_W-1:0] budget;
    logic [`SBA_CNT_W-1:0] refresh_cnt;
    logic [`SBA_NDMA-1:0][`SBA_CNT_W-1:0] tokens;
    logic [`SBA_NLAYER-1:0] layer_gnt;
    logic [`SBA_NDMA-1:0] dma_gnt;
    sba_dma_id_t dma_id;
    logic [31:0] rdata;
  } sba_state_t;

endpackage

// file: hw/sba_pick.sv
// Picks the valid requester with the largest key; ties go to the lowest index.
module sba_pick #(
  parameter int N = 4,
  parameter int W = 2
) (
  // Requests and keys
  input wire logic [N-1:0] valid_i,
  input wire logic [N*W-1:0] key_i,
  // One-hot winner
  output logic [N-1:0] win_o
);

  logic [W-1:0] best;
  logic found;

  always_comb begin
    best = '0;
    found = 1'b0;
    win_o = '0;
    for (int i = 0; i < N; i++) begin
      if (valid_i[i] && (!found || key_i[i*W +: W] > best)) begin
        best = key_i[i*W +: W];
        found = 1'b1;
        win_o = '0;
        win_o[i] = 1'b1;
      end
    end
  end

endmodule

// file: hw/sba_arbiter.sv
// System bus layer arbiter and dma layer arbiter with their configuration registers.
// Operation
// - Four layers, 2-bit code, lower code wins
// - Dma layer priority bits 7:6, reset 3
// - Cpu code layer bits 5:4, reset 2
// - Cpu system layer bits 3:2, reset 1
// - Radio controller layer bits 1:0, reset 0
// - Bridge bit 1 bypasses synchroniser stages
// - Bridge bit 0 bypasses bridge, equal clocks
// - Flash arbitration per transfer or per burst
// - Three dma masters, 4-bit priority, 15 highest
// - Master priorities reset to F, E, D
// - No request grants default master, reset 0
// - Default codes: dummy, test, general, item_a
// - Weighted token enable bit, reset 0
// - Refresh period reloads all token counters
// - Masters holding tokens beat exhausted masters
// - Zero budget means unlimited tokens
//
// Added by the designer: the plain strobed port.
`include "sba_regs.svh"

module sba_arbiter #(
  // Version word; the value is arbitrary.
  parameter logic [31:0] VERSION = 32'h00010000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // System bus layers: 0 radio controller, 1 cpu system, 2 cpu code, 3 dma
  input wire logic [`SBA_NLAYER-1:0] layer_req_i,
  input wire logic [`SBA_NLAYER-1:0] layer_burst_i,
  output logic [`SBA_NLAYER-1:0] layer_gnt_o,
  // Dma layer masters: 0 radio test port, 1 general dma, 2 item_a
  input wire logic [`SBA_NDMA-1:0] dma_req_i,
  output logic [`SBA_NDMA-1:0] dma_gnt_o,
  output logic [1:0] dma_gnt_id_o,
  // Bridge control
  output logic bridge_bypass_o,
  output logic sync_bypass_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] onehot_to_id(input logic [`SBA_NDMA-1:0] oh);
    logic [1:0] id;
    id = 2'h0;
    for (int i = 0; i < `SBA_NDMA; i++) begin
      if (oh[i]) begin
        id = 2'(i + 1);
      end
    end
    return id;
  endfunction

  function automatic logic [`SBA_NDMA-1:0] id_to_onehot(input logic [1:0] id);
    logic [`SBA_NDMA-1:0] oh;
    oh = '0;
    for (int i = 0; i < `SBA_NDMA; i++) begin
      if (id == 2'(i + 1)) begin
        oh[i] = 1'b1;
      end
    end
    return oh;
  endfunction

  sba_pkg::sba_state_t s_q, s_d;
  logic [`SBA_NLAYER*`SBA_LPRIO_W-1:0] layer_key;
  logic [`SBA_NDMA*(`SBA_MPRIO_W+1)-1:0] dma_key;
  logic [`SBA_NDMA-1:0] upper_tier;
  logic [`SBA_NLAYER-1:0] layer_win;
  logic [`SBA_NDMA-1:0] dma_win;
  logic [1:0] dflt_id;

  // ----------------------------------------
  // Arbitration keys
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SBA_NLAYER; g++) begin : g_layer
      // Inverted code so that code 0 gives the largest key.
      assign layer_key[g*`SBA_LPRIO_W +: `SBA_LPRIO_W] = ~s_q.layer_prio[g*`SBA_LPRIO_W +: `SBA_LPRIO_W];
    end
    for (g = 0; g < `SBA_NDMA; g++) begin : g_dma
      assign upper_tier[g] = (s_q.budget[g] == '0) || (s_q.tokens[g] != '0);
      assign dma_key[g*(`SBA_MPRIO_W+1) +: `SBA_MPRIO_W+1] = {s_q.wt_on & upper_tier[g], s_q.mprio[g]};
    end
  endgenerate

  sba_pick #(.N(`SBA_NLAYER), .W(`SBA_LPRIO_W)) u_layer_pick (
    .valid_i(layer_req_i),
    .key_i(layer_key),
    .win_o(layer_win)
  );

  sba_pick #(.N(`SBA_NDMA), .W(`SBA_MPRIO_W+1)) u_dma_pick (
    .valid_i(dma_req_i),
    .key_i(dma_key),
    .win_o(dma_win)
  );

  // Codes 0 and 4 upward select the dummy master.
  assign dflt_id = (s_q.dflt <= `SBA_DFLT_MAX) ? s_q.dflt[1:0] : 2'h0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    // Register writes; reserved bits are dropped.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SBA_A_LAYER_PRIO: s_d.layer_prio = reg_wdata_i[`SBA_NLAYER*`SBA_LPRIO_W-1:0];
        `SBA_A_BRIDGE: begin
          s_d.sync_byp = reg_wdata_i[`SBA_SYNC_BYP_BIT];
          s_d.bridge_byp = reg_wdata_i[`SBA_BRIDGE_BYP_BIT];
        end
        `SBA_A_FLASH_ARB: s_d.per_burst = reg_wdata_i[`SBA_PER_BURST_BIT];
        `SBA_A_PRIO1: s_d.mprio[0] = reg_wdata_i[`SBA_MPRIO_W-1:0];
        `SBA_A_PRIO2: s_d.mprio[1] = reg_wdata_i[`SBA_MPRIO_W-1:0];
        `SBA_A_PRIO3: s_d.mprio[2] = reg_wdata_i[`SBA_MPRIO_W-1:0];
        `SBA_A_DFLT: s_d.dflt = reg_wdata_i[`SBA_DFLT_W-1:0];
        `SBA_A_WT_EN: s_d.wt_on = reg_wdata_i[`SBA_WT_ON_BIT];
        `SBA_A_PERIOD: s_d.period = reg_wdata_i[`SBA_CNT_W-1:0];
        `SBA_A_BUDGET1: s_d.budget[0] = reg_wdata_i[`SBA_CNT_W-1:0];
        `SBA_A_BUDGET2: s_d.budget[1] = reg_wdata_i[`SBA_CNT_W-1:0];
        `SBA_A_BUDGET3: s_d.budget[2] = reg_wdata_i[`SBA_CNT_W-1:0];
        default: begin
        end
      endcase
    end
    // Register reads; unmapped addresses and reserved bits read zero.
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SBA_A_LAYER_PRIO: s_d.rdata = 32'(s_q.layer_prio);
        `SBA_A_BRIDGE: begin
          s_d.rdata[`SBA_SYNC_BYP_BIT] = s_q.sync_byp;
          s_d.rdata[`SBA_BRIDGE_BYP_BIT] = s_q.bridge_byp;
        end
        `SBA_A_FLASH_ARB: s_d.rdata[`SBA_PER_BURST_BIT] = s_q.per_burst;
        `SBA_A_STATUS: begin
          s_d.rdata[`SBA_NLAYER-1:0] = s_q.layer_gnt;
          s_d.rdata[`SBA_ST_DGNT_LSB +: `SBA_NDMA] = s_q.dma_gnt;
          s_d.rdata[`SBA_ST_DID_LSB +: 2] = s_q.dma_id;
          s_d.rdata[`SBA_ST_TIER_LSB +: `SBA_NDMA] = upper_tier;
        end
        `SBA_A_PRIO1: s_d.rdata = 32'(s_q.mprio[0]);
        `SBA_A_PRIO2: s_d.rdata = 32'(s_q.mprio[1]);
        `SBA_A_PRIO3: s_d.rdata = 32'(s_q.mprio[2]);
        `SBA_A_DFLT: s_d.rdata = 32'(s_q.dflt);
        `SBA_A_WT_EN: s_d.rdata[`SBA_WT_ON_BIT] = s_q.wt_on;
        `SBA_A_PERIOD: s_d.rdata = 32'(s_q.period);
        `SBA_A_BUDGET1: s_d.rdata = 32'(s_q.budget[0]);
        `SBA_A_BUDGET2: s_d.rdata = 32'(s_q.budget[1]);
        `SBA_A_BUDGET3: s_d.rdata = 32'(s_q.budget[2]);
        `SBA_A_VERSION: s_d.rdata = VERSION;
        default: begin
        end
      endcase
    end
    // Token bookkeeping: a new period reloads every counter, otherwise a granted
    // requesting master spends one token per bus cycle.
    if (s_q.refresh_cnt == '0) begin
      s_d.refresh_cnt = s_q.period;
      s_d.tokens = s_q.budget;
    end else begin
      s_d.refresh_cnt = s_q.refresh_cnt - 1'b1;
      for (int i = 0; i < `SBA_NDMA; i++) begin
        if (s_q.dma_gnt[i] && dma_req_i[i] && s_q.tokens[i] != '0) begin
          s_d.tokens[i] = s_q.tokens[i] - 1'b1;
        end
      end
    end
    // Layer grant: a burst keeps its grant in per-burst mode; otherwise every
    // transfer is arbitrated with the priorities in force now.
    if (!(s_q.per_burst && |(s_q.layer_gnt & layer_req_i & layer_burst_i))) begin
      s_d.layer_gnt = layer_win;
    end
    // Dma grant: highest key wins, the default master when nobody asks.
    if (|dma_req_i) begin
      s_d.dma_gnt = dma_win;
      s_d.dma_id = sba_pkg::sba_dma_id_t'(onehot_to_id(dma_win));
    end else begin
      s_d.dma_gnt = id_to_onehot(dflt_id);
      s_d.dma_id = sba_pkg::sba_dma_id_t'(dflt_id);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.layer_prio <= `SBA_LPRIO_RST;
      s_q.mprio <= `SBA_MPRIO_RST;
      s_q.dflt <= `SBA_DFLT_RST;
      s_q.period <= `SBA_PERIOD_RST;
      s_q.refresh_cnt <= `SBA_PERIOD_RST;
      s_q.budget <= {`SBA_NDMA{`SBA_BUDGET_RST}};
      s_q.tokens <= {`SBA_NDMA{`SBA_BUDGET_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign layer_gnt_o = s_q.layer_gnt;
  assign dma_gnt_o = s_q.dma_gnt;
  assign dma_gnt_id_o = s_q.dma_id;
  assign bridge_bypass_o = s_q.bridge_byp;
  assign sync_bypass_o = s_q.sync_byp;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [1:0] best_code;
  logic [1:0] gnt_code;

  always_comb begin
    best_code = 2'h3;
    gnt_code = 2'h0;
    for (int i = 0; i < `SBA_NLAYER; i++) begin
      if (layer_req_i[i] && s_q.layer_prio[i*`SBA_LPRIO_W +: `SBA_LPRIO_W] < best_code) begin
        best_code = s_q.layer_prio[i*`SBA_LPRIO_W +: `SBA_LPRIO_W];
      end
      if (layer_gnt_o[i]) begin
        gnt_code = s_q.layer_prio[i*`SBA_LPRIO_W +: `SBA_LPRIO_W];
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // A priority write in the deciding cycle renames the codes under the grant, so that cycle is left out.
  AST_LAYER_PRIO: assert property (|layer_req_i && !s_q.per_burst && !(reg_wr_i && reg_addr_i == `SBA_A_LAYER_PRIO)
      |=> gnt_code == $past(best_code))
    else $error("Layer grant does not carry the best priority code.");
  AST_LAYER_ONEHOT: assert property ($onehot0(layer_gnt_o))
    else $error("More than one layer granted.");
  AST_NO_REQ_NO_GNT: assert property (layer_req_i == '0 |=> layer_gnt_o == '0)
    else $error("Layer granted without a request.");
  AST_RADIO_WINS_AFTER_RESET: assert property ($fell(reset_i) && layer_req_i[0] |=> layer_gnt_o[0])
    else $error("Radio controller layer lost right after reset.");
  AST_SYNC_BYPASS: assert property (reg_wr_i && reg_addr_i == `SBA_A_BRIDGE
      |=> sync_bypass_o == $past(reg_wdata_i[`SBA_SYNC_BYP_BIT]))
    else $error("Synchroniser bypass output does not follow its write.");
  AST_BRIDGE_BYPASS: assert property (reg_wr_i && reg_addr_i == `SBA_A_BRIDGE
      |=> bridge_bypass_o == $past(reg_wdata_i[`SBA_BRIDGE_BYP_BIT]))
    else $error("Bridge bypass output does not follow its write.");
  AST_BURST_HOLD: assert property (s_q.per_burst && |(layer_gnt_o & layer_req_i & layer_burst_i)
      |=> $stable(layer_gnt_o))
    else $error("Grant moved in the middle of a burst.");
  AST_DMA_PRIO: assert property (!s_q.wt_on && dma_req_i[0] && dma_req_i[1] && s_q.mprio[0] > s_q.mprio[1]
      |=> !dma_gnt_o[1])
    else $error("Lower dma priority master was granted.");
  AST_DMA_DEFAULT: assert property (dma_req_i == '0 |=> dma_gnt_id_o == $past(dflt_id))
    else $error("Idle dma layer did not grant the default master.");
  AST_DUMMY_ID: assert property (dma_gnt_o == '0 |-> dma_gnt_id_o == sba_pkg::SBA_DM_DUMMY)
    else $error("Empty dma grant carries a real master id.");
  AST_TOKEN_SPEND: assert property (s_q.refresh_cnt != '0 && dma_gnt_o[0] && dma_req_i[0] && s_q.tokens[0] != '0
      |=> s_q.tokens[0] == $past(s_q.tokens[0]) - 16'h1)
    else $error("Granted master did not spend one token.");
  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("Read data present without a read.");
  AST_TOKEN_RELOAD: assert property (s_q.refresh_cnt == '0 |=> s_q.tokens == $past(s_q.budget))
    else $error("Token counters not reloaded at period start.");
  AST_TIER: assert property (s_q.wt_on && dma_req_i[0] && dma_req_i[1] && upper_tier[0] && !upper_tier[1]
      |=> !dma_gnt_o[1])
    else $error("Exhausted master beat a master holding tokens.");
  AST_UNLIMITED: assert property (s_q.budget[2] == '0 |-> upper_tier[2])
    else $error("Zero budget master fell out of the upper tier.");
  AST_RESERVED_ZERO: assert property (reg_rd_i && reg_addr_i == `SBA_A_PRIO1
      |=> reg_rdata_o[31:`SBA_MPRIO_W] == '0)
    else $error("Reserved bits read nonzero.");

  COV_LAYER_CONTEND: cover property (&layer_req_i ##1 layer_gnt_o[0]);
  COV_BURST_HOLD: cover property (s_q.per_burst && layer_burst_i[3] && layer_gnt_o[3] ##1 layer_gnt_o[3]);
  COV_TOKEN_OUT: cover property (s_q.wt_on && dma_req_i[0] && !upper_tier[0] ##1 !dma_gnt_o[0]);
  COV_DEFAULT: cover property (dma_req_i == '0 && dflt_id == 2'h2 ##1 dma_gnt_o[1]);

endmodule

// file: bench/sba_masters.sv
// Model of the bus masters that face the arbiter on the layer and dma sides.
module sba_masters (
  // Requests wanted by the bench
  input wire logic [3:0] want_req_i,
  input wire logic [3:0] want_burst_i,
  input wire logic [2:0] want_dma_i,
  // Request lines to the arbiter
  output logic [3:0] layer_req_o,
  output logic [3:0] layer_burst_o,
  output logic [2:0] dma_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A burst flag only ever qualifies a live request.
  assign layer_req_o = want_req_i;
  assign layer_burst_o = want_burst_i & want_req_i;
  assign dma_req_o = want_dma_i;
endmodule

// file: bench/sba_testbench.sv
// Self-checking bench of the system bus arbiter.
`include "sba_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic samp = 1'b0;
  logic [3:0] wreq = 4'h0;
  logic [3:0] wburst = 4'h0;
  logic [2:0] wdma = 3'h0;
  logic [3:0] lreq, lburst, lgnt;
  logic [2:0] dreq, dgnt;
  logic [1:0] did;
  logic bbyp, sbyp;
  logic [31:0] rdata;
  logic [31:0] rd_q[$];
  logic [10:0] gnt_q[$];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h3453A174;
  localparam logic [31:0] RA [12] = '{`SBA_A_LAYER_PRIO, `SBA_A_BRIDGE, `SBA_A_FLASH_ARB, `SBA_A_PRIO1,
    `SBA_A_PRIO2, `SBA_A_PRIO3, `SBA_A_DFLT, `SBA_A_WT_EN, `SBA_A_PERIOD, `SBA_A_BUDGET1, `SBA_A_BUDGET2,
    `SBA_A_BUDGET3};
  localparam logic [31:0] RV [12] = '{32'hE4, 32'h0, 32'h0, 32'hF, 32'hE, 32'hD, 32'h0, 32'h0, 32'hFFFF,
    32'hF, 32'hF, 32'hF};

  always #4 clk_i = ~clk_i;

  sba_masters master_u (.want_req_i(wreq), .want_burst_i(wburst), .want_dma_i(wdma),
    .layer_req_o(lreq), .layer_burst_o(lburst), .dma_req_o(dreq));
  sba_arbiter dut_u (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .layer_req_i(lreq), .layer_burst_i(lburst),
    .layer_gnt_o(lgnt), .dma_req_i(dreq), .dma_gnt_o(dgnt), .dma_gnt_id_o(did),
    .bridge_bypass_o(bbyp), .sync_bypass_o(sbyp));

  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask

  task automatic reg_rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    tick(1);
  endtask

  task automatic exp_g(input logic [3:0] l, input logic [2:0] d, input logic [1:0] i, input logic [1:0] b);
    gnt_q.push_back({l, d, i, b});
    samp <= 1'b1;
    tick(1);
    samp <= 1'b0;
    tick(1);
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_g(input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  function automatic logic [3:0] lwin(input logic [3:0] r, input logic [7:0] p);
    logic [3:0] w;
    logic [2:0] best;
    w = 4'h0;
    best = 3'h4;
    for (int i = 0; i < 4; i++) begin
      if (r[i] && {1'b0, p[2*i+:2]} < best) begin
        best = {1'b0, p[2*i+:2]};
        w = 4'h1 << i;
      end
    end
    return w;
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Result watcher and hang guard
  // ----------------------------------------
  always @(posedge clk_i) rd_d <= rd;

  always @(negedge clk_i) begin
    if (rd_d && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), rdata);
    if (samp && gnt_q.size() > 0) cmp_g(gnt_q.pop_front(), {lgnt, dgnt, did, bbyp, sbyp});
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    tick(6);
    reset_i <= 1'b0;
    tick(1);
    for (int i = 0; i < 12; i++) reg_rd(RA[i], RV[i]);
    reg_rd(32'h50060410, 32'h0);
    reg_wr(`SBA_A_PRIO1, 32'hFFFFFFFF);
    reg_rd(`SBA_A_PRIO1, 32'hF);
    reg_wr(`SBA_A_VERSION, 32'h0);
    reg_rd(`SBA_A_VERSION, 32'h00010000);
    // Tokens are still untouched here, so the tier switch time is known.
    reg_wr(`SBA_A_WT_EN, 32'hFFFFFFFF);
    reg_rd(`SBA_A_WT_EN, 32'h1);
    wdma <= 3'h3;
    tick(1);
    exp_g(4'h0, 3'h1, 2'h1, 2'h0);
    tick(18);
    exp_g(4'h0, 3'h2, 2'h2, 2'h0);
    reg_wr(`SBA_A_BUDGET1, 32'h0);
    exp_g(4'h0, 3'h1, 2'h1, 2'h0);
    reg_wr(`SBA_A_WT_EN, 32'h0);
    reg_wr(`SBA_A_PRIO1, 32'h2);
    wdma <= 3'h7;
    tick(1);
    exp_g(4'h0, 3'h2, 2'h2, 2'h0);
    wdma <= 3'h5;
    tick(1);
    exp_g(4'h0, 3'h4, 2'h3, 2'h0);
    wdma <= 3'h0;
    for (int d = 0; d < 5; d++) begin
      reg_wr(`SBA_A_DFLT, d);
      exp_g(4'h0, (d >= 1 && d <= 3) ? 3'h1 << (d - 1) : 3'h0, (d <= 3) ? d[1:0] : 2'h0, 2'h0);
    end
    wreq <= 4'hF;
    tick(1);
    exp_g(4'h1, 3'h0, 2'h0, 2'h0);
    for (int n = 0; n < 24; n++) begin
      rng = xs(rng);
      reg_wr(`SBA_A_LAYER_PRIO, {24'h0, rng[7:0]});
      wreq <= rng[11:8];
      reg_rd(`SBA_A_LAYER_PRIO, {24'h0, rng[7:0]});
      exp_g(lwin(rng[11:8], rng[7:0]), 3'h0, 2'h0, 2'h0);
    end
    reg_wr(`SBA_A_LAYER_PRIO, 32'hE4);
    for (int m = 1; m >= 0; m--) begin
      reg_wr(`SBA_A_FLASH_ARB, m);
      wreq <= 4'h4;
      wburst <= 4'h4;
      tick(1);
      exp_g(4'h4, 3'h0, 2'h0, 2'h0);
      wreq <= 4'h5;
      tick(1);
      exp_g((m == 1) ? 4'h4 : 4'h1, 3'h0, 2'h0, 2'h0);
      wburst <= 4'h0;
      tick(1);
      exp_g(4'h1, 3'h0, 2'h0, 2'h0);
    end
    wreq <= 4'h0;
    // Both clocks are the same here, so bridge bypass may be set.
    reg_wr(`SBA_A_BRIDGE, 32'hFFFFFFFF);
    exp_g(4'h0, 3'h0, 2'h0, 2'h3);
    reg_wr(`SBA_A_BRIDGE, 32'h2);
    exp_g(4'h0, 3'h0, 2'h0, 2'h1);
    reg_rd(`SBA_A_BRIDGE, 32'h2);
    finish_test();
  end
endmodule
